// ---- hw/clock_gate_consts.svh ----
// constants of the clock gating and pll configuration bank
// assumes a 32-bit apb slave clocked at 200 mhz
`ifndef CLOCK_GATE_CONSTS_SVH
`define CLOCK_GATE_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PER_EN_OFS 12'h004
`define CORE_EN_OFS 12'h008
`define CLK_CFG_OFS 12'h00C
`define CFG_KEY_OFS 12'h014

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PER_EN_RST 32'h0000_0077
`define PER_EN_MASK 32'h0000_0076
`define CORE_EN_RST 32'h0000_0007
`define CORE_EN_MASK 32'h0000_0007
`define CLK_CFG_RST 32'h0528_0400
`define CFG_KEY_WORD 32'h78b4_65a1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TIMER_FUNC_BIT 6
`define TIMER_BUS_BIT 5
`define POWER_UNIT_BIT 4
`define SYSCONF_BIT 2
`define INTERRUPT_UNIT_BIT 1
`define CORE_FAST_BIT 2
`define CORE_MID_BIT 1
`define CORE_SLOW_BIT 0
`define BW_LSB 24
`define BW_MSB 27
`define MULT_LSB 16
`define MULT_MSB 21
`define DIV_LSB 8
`define DIV_MSB 10
`define PLL_LOCK_BIT 5
`define OSC_STABLE_BIT 3
`define MULT_MIN 6'h08

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CORE_CLK_MHZ 200
`define PLL_RELOCK_NS 500

`endif

// ---- hw/clock_gate_pkg.sv ----
// types shared by the clock gating bank and its helpers
// assumes nothing beyond the constants header
package clock_gate_pkg;

  typedef struct packed {
    logic [6:0] per_en;
    logic [2:0] core_en;
    logic [3:0] pll_bandwidth;
    logic [5:0] pll_multiplier;
    logic [2:0] pll_out_divider;
    logic cfg_key;
    logic osc_stable;
    logic [2:0] div_cnt;
    logic [31:0] rdata;
  } bank_state_t;

  typedef struct packed {
    logic held;
  } gate_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic locked;
  } relock_state_t;

endpackage

// ---- hw/clk_tick_gate.sv ----
// one glitch-free gate on a clock expressed as an enable pulse
// assumes tick_i is a one-cycle pulse per period of the gated clock
module clk_tick_gate
  import clock_gate_pkg::*;
#(
  parameter logic RESET_ON = 1'b1
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // gate
  input wire logic tick_i,
  input wire logic on_i,
  output logic tick_o
);
  import clock_gate_pkg::*;

  gate_state_t st;
  gate_state_t next_st;

  // the enable is only taken at a period boundary, so a period is
  // either passed whole or dropped whole
  always_comb
  begin
    next_st = st;
    if (tick_i)
    begin
      next_st.held = on_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '{held: RESET_ON};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick_o = tick_i & st.held;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_NO_RUNT: assert property (st.held != $past(st.held) |-> $past(tick_i))
    else $error("gate enable changed inside a clock period");
endmodule

// ---- hw/pll_relock_timer.sv ----
// holds the pll stable flag low for a relock time after a change
// assumes lock_i is the pll's own lock level, synchronous to the clock
module pll_relock_timer
  import clock_gate_pkg::*;
#(
  parameter int RELOCK_CYCLES = 100
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic restart_i,
  input wire logic lock_i,
  output logic locked_o
);
  import clock_gate_pkg::*;

  relock_state_t st;
  relock_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (restart_i)
    begin
      next_st.cnt = 16'(RELOCK_CYCLES);
    end
    else if (st.cnt != 16'h0000)
    begin
      next_st.cnt = st.cnt - 16'h0001;
    end
    next_st.locked = lock_i && !restart_i && (st.cnt == 16'h0000);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '{cnt: 16'(RELOCK_CYCLES), locked: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign locked_o = st.locked;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_held_low;
    !locked_o [*8];
  endsequence

  AST_RELOCK_DROP: assert property (restart_i |=> seq_held_low)
    else $error("pll stable flag rose too soon after a change");
  AST_LOCK_NEEDS_PLL: assert property (locked_o |-> $past(lock_i))
    else $error("pll stable flag set without pll lock");
endmodule

// ---- hw/clock_gate_and_pll_config.sv ----
// clock gating and pll configuration bank with an apb register slave
// assumes apb3 with zero wait states; pll and oscillator are analog
// blocks outside, reporting their state on osc_ok_i and pll_lock_i
//
// Behaviour
// - enable bit 6 gates the timer function clock; software only.
// - enable bit 5 gates the timer bus clock.
// - enable bits 4, 2, 1 gate power, sysconf and interrupt clocks.
// - peripheral enables at 0x04, reset 0x0000_0077.
// - core enable bits 2, 1, 0 gate the fast, mid, slow core clocks.
// - core enables at 0x08, reset 0x0000_0007.
// - pll fields read and write only while the key bit is 1.
// - writing 0x78b465a1 to offset 0x14 sets the key bit.
// - bits 27:24 hold pll bandwidth, passed to the pll.
// - bits 21:16 are the multiplier; codes below 8 are reserved.
// - bits 10:8 give the output divider as code plus one.
// - clock configuration at 0x0C, reset 0x0528_0400.
// - read-only bit 5 shows pll stable.
// - read-only bit 3 shows oscillator stable.
// - oscillator clock is withheld until its stable flag is set.
//
// Design decision made here: the APB slave port.
`include "clock_gate_consts.svh"

module clock_gate_and_pll_config
  import clock_gate_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int RELOCK_NS = `PLL_RELOCK_NS
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog status
  input wire logic osc_ok_i,
  input wire logic pll_lock_i,
  // pll control
  output logic [3:0] pll_bandwidth_o,
  output logic [5:0] pll_multiplier_o,
  output logic [2:0] pll_out_divider_o,
  output logic osc_release_o,
  // gated peripheral clock pulses
  output logic timer_func_clk_o,
  output logic timer_clk_o,
  output logic power_unit_clk_o,
  output logic sysconf_clk_o,
  output logic interrupt_unit_clk_o,
  // gated core clock pulses
  output logic core_clk_fast_o,
  output logic core_clk_mid_o,
  output logic core_clk_slow_o
);
  import clock_gate_pkg::*;

  // least relock time, rounded up to whole cycles
  localparam int RELOCK_CYCLES = (RELOCK_NS * `CORE_CLK_MHZ + 999) / 1000;
  localparam int NGATE = 8;

  bank_state_t st;
  bank_state_t next_st;
  logic pll_locked_flag;
  logic pll_restart;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_per;
  logic hit_core;
  logic hit_cfg;
  logic hit_key;
  logic [5:0] wr_mult;
  logic [2:0] wr_div;
  logic cfg_wr_ok;

  assign setup_ph = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign wr_en = access_ph && pwrite_i;
  assign hit_per = paddr_i == ADDR_W'(`PER_EN_OFS);
  assign hit_core = paddr_i == ADDR_W'(`CORE_EN_OFS);
  assign hit_cfg = paddr_i == ADDR_W'(`CLK_CFG_OFS);
  assign hit_key = paddr_i == ADDR_W'(`CFG_KEY_OFS);
  assign wr_mult = pwdata_i[`MULT_MSB:`MULT_LSB];
  assign wr_div = pwdata_i[`DIV_MSB:`DIV_LSB];
  assign cfg_wr_ok = wr_en && hit_cfg && st.cfg_key;

  // zero wait states; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph && !(hit_per || hit_core || hit_cfg || hit_key);
  assign prdata_o = st.rdata;

  // a relock is needed only when the pll ratio really changes
  assign pll_restart = cfg_wr_ok
    && (((wr_mult >= `MULT_MIN) && (wr_mult != st.pll_multiplier))
    || (wr_div != st.pll_out_divider));

  // ----------------------------------------------------------------
  // read mux, sampled in the setup cycle
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input bank_state_t s, input logic lk,
                                            input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == ADDR_W'(`PER_EN_OFS))
    begin
      w[6:0] = s.per_en;
    end
    else if (a == ADDR_W'(`CORE_EN_OFS))
    begin
      w[2:0] = s.core_en;
    end
    else if (a == ADDR_W'(`CLK_CFG_OFS))
    begin
      if (s.cfg_key)
      begin
        w[`BW_MSB:`BW_LSB] = s.pll_bandwidth;
        w[`MULT_MSB:`MULT_LSB] = s.pll_multiplier;
        w[`DIV_MSB:`DIV_LSB] = s.pll_out_divider;
      end
      w[`PLL_LOCK_BIT] = lk;
      w[`OSC_STABLE_BIT] = s.osc_stable;
    end
    else if (a == ADDR_W'(`CFG_KEY_OFS))
    begin
      w[0] = s.cfg_key;
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.osc_stable = osc_ok_i;
    next_st.div_cnt = st.div_cnt + 3'h1;
    if (setup_ph && !pwrite_i)
    begin
      next_st.rdata = read_word(st, pll_locked_flag, paddr_i);
    end
    if (wr_en && hit_per)
    begin
      next_st.per_en = pwdata_i[6:0] & 7'(`PER_EN_MASK);
    end
    if (wr_en && hit_core)
    begin
      next_st.core_en = pwdata_i[2:0] & 3'(`CORE_EN_MASK);
    end
    if (cfg_wr_ok)
    begin
      next_st.pll_bandwidth = pwdata_i[`BW_MSB:`BW_LSB];
      // a reserved multiplier code is refused, keeping the pll in range
      if (wr_mult >= `MULT_MIN)
      begin
        next_st.pll_multiplier = wr_mult;
      end
      next_st.pll_out_divider = wr_div;
    end
    if (wr_en && hit_key)
    begin
      next_st.cfg_key = (pwdata_i == `CFG_KEY_WORD);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.per_en <= 7'(`PER_EN_RST);
      st.core_en <= 3'(`CORE_EN_RST);
      st.pll_bandwidth <= 4'(`CLK_CFG_RST >> `BW_LSB);
      st.pll_multiplier <= 6'(`CLK_CFG_RST >> `MULT_LSB);
      st.pll_out_divider <= 3'(`CLK_CFG_RST >> `DIV_LSB);
      st.cfg_key <= 1'b0;
      st.osc_stable <= 1'b0;
      st.div_cnt <= 3'h0;
      st.rdata <= 32'h0000_0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pll_bandwidth_o = st.pll_bandwidth;
  assign pll_multiplier_o = st.pll_multiplier;
  assign pll_out_divider_o = st.pll_out_divider;
  assign osc_release_o = st.osc_stable;

  // ----------------------------------------------------------------
  // pll stable flag
  // ----------------------------------------------------------------
  pll_relock_timer #(
    .RELOCK_CYCLES(RELOCK_CYCLES)
  ) u_relock (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .restart_i(pll_restart),
    .lock_i(pll_lock_i && st.osc_stable),
    .locked_o(pll_locked_flag)
  );

  // ----------------------------------------------------------------
  // clock gates
  // ----------------------------------------------------------------
  // peripheral clocks run from the oscillator, core clocks from the
  // pll taps; neither exists before its source is stable
  logic [NGATE-1:0] src_tick;
  logic [NGATE-1:0] gate_on;
  logic [NGATE-1:0] gated;

  assign src_tick[0] = st.osc_stable;
  assign src_tick[1] = st.osc_stable;
  assign src_tick[2] = st.osc_stable;
  assign src_tick[3] = st.osc_stable;
  assign src_tick[4] = st.osc_stable;
  assign src_tick[5] = pll_locked_flag && st.osc_stable && st.div_cnt[0];
  assign src_tick[6] = pll_locked_flag && st.osc_stable && (st.div_cnt[1:0] == 2'h3);
  assign src_tick[7] = pll_locked_flag && st.osc_stable && (st.div_cnt == 3'h7);

  assign gate_on[0] = st.per_en[`TIMER_FUNC_BIT];
  assign gate_on[1] = st.per_en[`TIMER_BUS_BIT];
  assign gate_on[2] = st.per_en[`POWER_UNIT_BIT];
  assign gate_on[3] = st.per_en[`SYSCONF_BIT];
  assign gate_on[4] = st.per_en[`INTERRUPT_UNIT_BIT];
  assign gate_on[5] = st.core_en[`CORE_FAST_BIT];
  assign gate_on[6] = st.core_en[`CORE_MID_BIT];
  assign gate_on[7] = st.core_en[`CORE_SLOW_BIT];

  for (genvar g = 0; g < NGATE; g++)
  begin : gen_gate
    clk_tick_gate #(
      .RESET_ON(1'b1)
    ) u_gate (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(src_tick[g]),
      .on_i(gate_on[g]),
      .tick_o(gated[g])
    );
  end

  assign timer_func_clk_o = gated[0];
  assign timer_clk_o = gated[1];
  assign power_unit_clk_o = gated[2];
  assign sysconf_clk_o = gated[3];
  assign interrupt_unit_clk_o = gated[4];
  assign core_clk_fast_o = gated[5];
  assign core_clk_mid_o = gated[6];
  assign core_clk_slow_o = gated[7];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_cfg_write_locked;
    wr_en && hit_cfg && !st.cfg_key;
  endsequence

  sequence seq_cfg_read_locked;
    setup_ph && !pwrite_i && hit_cfg && !st.cfg_key ##1 access_ph;
  endsequence

  // a gate saw its enable at a source pulse, enable unchanged after
  sequence seq_gate_took(en, tk);
    en && tk ##1 en;
  endsequence

  AST_KEY_SET: assert property (wr_en && hit_key && pwdata_i == `CFG_KEY_WORD
      |=> st.cfg_key)
    else $error("key word did not set the key bit");
  AST_CFG_WRITE_BLOCKED: assert property (seq_cfg_write_locked |=> $stable(pll_multiplier_o)
      && $stable(pll_out_divider_o) && $stable(pll_bandwidth_o))
    else $error("pll fields changed without the key");
  AST_CFG_READ_HIDDEN: assert property (seq_cfg_read_locked
      |-> prdata_o[27:8] == 20'h0_0000)
    else $error("pll fields read without the key");
  AST_PER_WRITE: assert property (wr_en && hit_per
      |=> st.per_en == (7'($past(pwdata_i)) & 7'h76))
    else $error("peripheral enable write not taken");
  AST_CORE_WRITE: assert property (wr_en && hit_core
      |=> st.core_en == 3'($past(pwdata_i)))
    else $error("core enable write not taken");
  AST_MULT_RESERVED: assert property (cfg_wr_ok && wr_mult < 6'h08
      |=> $stable(pll_multiplier_o))
    else $error("reserved multiplier code accepted");
  AST_OSC_WITHHELD: assert property (!st.osc_stable |-> gated == 8'h00)
    else $error("clock passed before oscillator stable");
  AST_CORE_STOPPED: assert property (seq_gate_took(!st.core_en[2], src_tick[5])
      |-> !core_clk_fast_o)
    else $error("fast core clock ran while disabled");
  AST_LOCK_READ: assert property (setup_ph && !pwrite_i && hit_cfg
      |=> prdata_o[5] == $past(pll_locked_flag) && prdata_o[3] == $past(st.osc_stable))
    else $error("status bits misreported");
  AST_KEY_CLEAR: assert property (wr_en && hit_key && pwdata_i != `CFG_KEY_WORD
      |=> !st.cfg_key)
    else $error("wrong key word left the key bit set");
  AST_CFG_TAKEN: assert property (cfg_wr_ok |=>
      pll_bandwidth_o == 4'($past(pwdata_i) >> `BW_LSB)
      && pll_out_divider_o == $past(wr_div))
    else $error("keyed pll write not taken");
  AST_MULT_TAKEN: assert property (cfg_wr_ok && wr_mult >= `MULT_MIN
      |=> pll_multiplier_o == $past(wr_mult))
    else $error("valid multiplier code not taken");
  AST_RELOCK_START: assert property (pll_restart |=> !pll_locked_flag)
    else $error("pll stable flag kept after a ratio change");
  // the flag trails the analog level by one register stage
  AST_OSC_FLAG: assert property (!$past(rst_i)
      |-> osc_release_o == $past(osc_ok_i))
    else $error("oscillator flag does not follow the oscillator");
  // core taps are fixed fractions of the bank clock
  AST_FAST_RATE: assert property (core_clk_fast_o |=> !core_clk_fast_o)
    else $error("fast core pulses too close");
  AST_MID_RATE: assert property (core_clk_mid_o |=> !core_clk_mid_o [*3])
    else $error("mid core pulses too close");
  AST_SLOW_RATE: assert property (core_clk_slow_o |=> !core_clk_slow_o [*7])
    else $error("slow core pulses too close");

  // per gate: a period seen with the enable low is dropped, one seen high passes
  for (genvar g = 0; g < NGATE; g++)
  begin : gen_gate_chk
    AST_GATE_STOPPED: assert property (@(posedge core_clk_i) disable iff (rst_i)
        seq_gate_took(!gate_on[g], src_tick[g]) |-> !gated[g])
      else $error("gated clock ran while disabled");
    AST_GATE_RUNNING: assert property (@(posedge core_clk_i) disable iff (rst_i)
        seq_gate_took(gate_on[g], src_tick[g]) ##0 src_tick[g] |-> gated[g])
      else $error("enabled clock pulse was dropped");
  end
endmodule

// ---- tb/clock_gate_and_pll_config_bench.sv ----
// self-checking bench for the clock gating and pll configuration bank
// assumes the package and the constants header are compiled first
`include "clock_gate_consts.svh"
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module clock_gate_and_pll_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_gate_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, osc_ok_i, pll_lock_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, osc_release_o;
  logic [3:0] pll_bandwidth_o;
  logic [5:0] pll_multiplier_o;
  logic [2:0] pll_out_divider_o;
  logic timer_func_clk_o, timer_clk_o, power_unit_clk_o, sysconf_clk_o, interrupt_unit_clk_o;
  logic core_clk_fast_o, core_clk_mid_o, core_clk_slow_o;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0001_1f29;

  // relock shortened to 20 cycles at 200 mhz
  clock_gate_and_pll_config #(.ADDR_W(12), .RELOCK_NS(100)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .osc_ok_i(osc_ok_i),
    .pll_lock_i(pll_lock_i), .pll_bandwidth_o(pll_bandwidth_o),
    .pll_multiplier_o(pll_multiplier_o), .pll_out_divider_o(pll_out_divider_o),
    .osc_release_o(osc_release_o), .timer_func_clk_o(timer_func_clk_o),
    .timer_clk_o(timer_clk_o), .power_unit_clk_o(power_unit_clk_o),
    .sysconf_clk_o(sysconf_clk_o), .interrupt_unit_clk_o(interrupt_unit_clk_o),
    .core_clk_fast_o(core_clk_fast_o), .core_clk_mid_o(core_clk_mid_o),
    .core_clk_slow_o(core_clk_slow_o));

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    repeat (8) seed = lfsr_next(seed);
    v = seed;
  endtask

  // pll fields read back only with the key set; status bits always
  function automatic logic [31:0] cfg_exp(input logic key, input logic [3:0] bw,
    input logic [5:0] m, input logic [2:0] d, input logic pll, input logic osc);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (key)
      v = {4'h0, bw, 2'b00, m, 5'h00, d, 8'h00};
    v[`PLL_LOCK_BIT] = pll;
    v[`OSC_STABLE_BIT] = osc;
    return v;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // wait for pready_o high; the watchdog ends it if pready_o never rises
    do
    begin
      @(posedge core_clk_i);
    end
    while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  // poll the configuration register until the pll flag shows, bounded
  task automatic wait_lock(output logic [31:0] r);
    int n;
    n = 0;
    do
    begin
      rd(`CLK_CFG_OFS, r);
      n++;
    end
    while (r[`PLL_LOCK_BIT] !== 1'b1 && n < 60);
    `CHK(r[`PLL_LOCK_BIT], 1'b1)
  endtask

  task automatic count16(output int f, output int m, output int s);
    f = 0;
    m = 0;
    s = 0;
    repeat (16)
    begin
      @(negedge core_clk_i);
      f += int'(core_clk_fast_o === 1'b1);
      m += int'(core_clk_mid_o === 1'b1);
      s += int'(core_clk_slow_o === 1'b1);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    err_total++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r, v, w;
    logic e;
    logic [3:0] bw_s;
    logic [5:0] m_s, m;
    logic [2:0] d_s;
    int f, mc, sc;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    osc_ok_i = 1'b0;
    pll_lock_i = 1'b0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;

    rd(`PER_EN_OFS, r);
    `CHK(r, 32'h0000_0077)
    rd(`CORE_EN_OFS, r);
    `CHK(r, 32'h0000_0007)
    rd(`CLK_CFG_OFS, r);
    `CHK(r, cfg_exp(1'b0, 4'h0, 6'h00, 3'h0, 1'b0, 1'b0))
    `CHK({pll_bandwidth_o, pll_multiplier_o, pll_out_divider_o}, {4'h5, 6'h28, 3'h4})
    `CHK({osc_release_o, timer_func_clk_o, timer_clk_o}, 3'b000)
    $display("test reset done");

    // oscillator and pll lock come up in the same cycle
    osc_ok_i <= 1'b1;
    pll_lock_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    `CHK(osc_release_o, 1'b1)
    wait_lock(r);
    `CHK(r, cfg_exp(1'b0, 4'h0, 6'h00, 3'h0, 1'b1, 1'b1))
    wr(`CFG_KEY_OFS, `CFG_KEY_WORD);
    rd(`CLK_CFG_OFS, r);
    `CHK(r, cfg_exp(1'b1, 4'h5, 6'h28, 3'h4, 1'b1, 1'b1))
    `CHK(r & 32'h0f3f_0700, 32'h0528_0400)
    apb(1'b0, 12'h040, 32'h0000_0000, r, e);
    `CHK({e, r}, {1'b1, 32'h0000_0000})
    $display("test status and key done");

    // peripheral gates, corners first then random
    for (int i = 0; i < 6; i++)
    begin
      rnd(v);
      if (i == 0)
        v = 32'h0000_0000;
      if (i == 1)
        v = 32'hffff_ffff;
      w = (v & 32'h0000_0076) | 32'h0000_0001;
      wr(`PER_EN_OFS, w);
      rd(`PER_EN_OFS, r);
      `CHK(r & 32'h0000_0076, w & 32'h0000_0076)
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
      `CHK({timer_func_clk_o, timer_clk_o, power_unit_clk_o, 1'b0, sysconf_clk_o,
        interrupt_unit_clk_o, 1'b0}, w[6:0] & 7'h76)
    end
    $display("test peripheral gates done");

    // core gates: exact pulse counts show no runt or lost pulses
    for (int i = 0; i < 6; i++)
    begin
      rnd(v);
      if (i < 3)
        v = 32'h0000_0001 << i;
      w = v & 32'h0000_0007;
      wr(`CORE_EN_OFS, w);
      rd(`CORE_EN_OFS, r);
      `CHK(r, w)
      repeat (10) @(posedge core_clk_i);
      count16(f, mc, sc);
      `CHK(f, w[`CORE_FAST_BIT] ? 8 : 0)
      `CHK(mc, w[`CORE_MID_BIT] ? 4 : 0)
      `CHK(sc, w[`CORE_SLOW_BIT] ? 2 : 0)
    end
    $display("test core gates done");

    // pll fields: every divider code, multiplier boundaries and reserved codes
    bw_s = 4'h5;
    m_s = 6'h28;
    d_s = 3'h4;
    for (int i = 0; i < 8; i++)
    begin
      rnd(v);
      m = (i == 0) ? 6'h07 : (i == 1) ? 6'h08 : (i == 2) ? 6'h3f : v[13:8];
      bw_s = v[3:0];
      d_s = 3'(i);
      if (m >= `MULT_MIN)
        m_s = m;
      wr(`CLK_CFG_OFS, {4'h0, v[3:0], 2'b00, m, 5'h00, 3'(i), 8'h00});
      @(negedge core_clk_i);
      `CHK({pll_bandwidth_o, pll_multiplier_o, pll_out_divider_o}, {bw_s, m_s, d_s})
      rd(`CLK_CFG_OFS, r);
      `CHK(r & ~32'h0000_0020, cfg_exp(1'b1, bw_s, m_s, d_s, 1'b0, 1'b1))
    end
    wait_lock(r);
    $display("test pll fields done");

    // relock after a divider change, and no lock while the pll reports none
    wr(`CLK_CFG_OFS, {4'h0, bw_s, 2'b00, m_s, 5'h00, d_s + 3'h1, 8'h00});
    rd(`CLK_CFG_OFS, r);
    `CHK(r[`PLL_LOCK_BIT], 1'b0)
    pll_lock_i <= 1'b0;
    repeat (40) @(posedge core_clk_i);
    rd(`CLK_CFG_OFS, r);
    `CHK(r[`PLL_LOCK_BIT], 1'b0)
    pll_lock_i <= 1'b1;
    wait_lock(r);
    `CHK(r[`PLL_LOCK_BIT], 1'b1)
    $display("test relock done");

    // any other key word locks the pll fields again
    wr(`CFG_KEY_OFS, 32'h0000_0000);
    wr(`CLK_CFG_OFS, {4'h0, ~bw_s, 2'b00, 6'h3f, 5'h00, 3'h0, 8'h00});
    @(negedge core_clk_i);
    `CHK({pll_bandwidth_o, pll_multiplier_o, pll_out_divider_o}, {bw_s, m_s, d_s + 3'h1})
    rd(`CLK_CFG_OFS, r);
    `CHK(r, cfg_exp(1'b0, 4'h0, 6'h00, 3'h0, 1'b1, 1'b1))
    $display("test key lock done");

    // reset in mid-run brings the changed registers back
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(`PER_EN_OFS, r);
    `CHK(r, `PER_EN_RST)
    rd(`CORE_EN_OFS, r);
    `CHK(r, `CORE_EN_RST)
    `CHK({pll_bandwidth_o, pll_multiplier_o, pll_out_divider_o}, {4'h5, 6'h28, 3'h4})
    $display("test reset in run done");
    tally_and_finish();
  end
endmodule
